/* hw/wkirq_pkg.sv */
// Package: register map, field positions and timing for the wake-event interrupt block
// How it works
// - The supply-level change detector is always armed; each of the four pin detectors has its own enable.
// - In suspend with remote wakeup, mask bit 2 and the detector enabled, an event restarts the clock, raises the wake interrupt and schedules resume.
// - Resume signalling starts when firmware clears the wake interrupt or 10 ms after it was raised, whichever is first.
// - With remote wakeup and low power both off, the clock runs through suspend and events interrupt as usual.
// - With low power on, the clock stops in suspend; unless remote wakeup and mask bit 2 are on, events are only captured, without an interrupt.
// - With remote wakeup off the clock stays stopped until the host resumes; then the captured event interrupts.
// - Control bit 6 is the low-power enable that decides clock shutdown in suspend.
// - Mask bit 2 gates the wake interrupt and, with remote wakeup, gates clock wakeup in suspend.
// - Control bit 5 is the remote wakeup enable; it gates clock wakeup and upstream resume.
// - Config bit 2 enables change detection on pin 4 of the port, bit 3 on pin 5.
// - Config bit 4 enables card-detect A on pin 2 of the port, bit 5 card-detect B on pin 3.
// - Each detector gives a one-cycle pulse; the ORed pulse sets the shared wake bit only when enabled, whether or not it is already set.
// - Writing one to the shared wake bit clears the pending interrupt; per-source bits stay set.
// - Each per-source bit clears only on a write of one; firmware clears the shared bit first.
package wkirq_pkg;
	// Register byte offsets, one aligned word each
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_MASK = 8'h04;
	localparam logic [7:0] OFF_CONTROL = 8'h08;
	localparam logic [7:0] OFF_CPU_CFG = 8'h0c;
	localparam logic [7:0] OFF_WK_SRC = 8'h10;
	// Field positions
	localparam int BIT_WAKE = 2;
	localparam int BIT_WAKE_EN = 2;
	localparam int BIT_RWU_EN = 5;
	localparam int BIT_LP_EN = 6;
	localparam int BIT_GPIO4_EN = 2;
	localparam int BIT_GPIO5_EN = 3;
	localparam int BIT_CDA_EN = 4;
	localparam int BIT_CDB_EN = 5;
	// Source index inside the wakeup source register
	localparam int SRC_VBUS = 0;
	localparam int SRC_CDA = 1;
	localparam int SRC_CDB = 2;
	localparam int SRC_GPIO4 = 3;
	localparam int SRC_GPIO5 = 4;
	localparam int NSRC = 5;
	// Reset values
	localparam logic [7:0] RST_REG = 8'h00;
	// Timing
	localparam int CLK_HZ = 40000000;
	localparam int RESUME_DELAY_MS = 10;
	localparam int RESUME_CYC = RESUME_DELAY_MS * (CLK_HZ / 1000);
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Resume scheduler states
	typedef enum logic [2:0] {
		RS_IDLE = 3'h1,
		RS_WAIT = 3'h2,
		RS_SEND = 3'h4
	} wkirq_rs_t;
endpackage : wkirq_pkg

/* hw/wkirq_sync_latch.sv */
// Capture of stopped-clock events and their synchroniser into the core domain
`timescale 1ns/1ps
module wkirq_sync_latch #(
	parameter int W = 5
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [W-1:0] i_capture,
	input wire logic i_release,
	output logic [W-1:0] o_evt
);
	typedef struct packed {
		logic [W-1:0] hold;
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] done;
		logic [W-1:0] evt;
	} wkirq_sl_t;

	wkirq_sl_t r_r;
	wkirq_sl_t r_nxt;

	////////////////////////////////////////////////////////////////
	// Held events cross two flops; only s2 is looked at downstream
	always_comb begin
		r_nxt = r_r;
		r_nxt.s1 = r_r.hold;
		r_nxt.s2 = r_r.s1;
		// Released once per capture; done blocks the stale s2 tail
		r_nxt.evt = r_r.s2 & ~r_r.done & {W{i_release}};
		r_nxt.done = (r_r.done | r_nxt.evt) & r_r.s2;
		// New capture wins over the clear of the same bit
		r_nxt.hold = i_capture | (r_r.hold & ~r_nxt.evt);
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign o_evt = r_r.evt;
endmodule : wkirq_sync_latch

/* hw/wkirq_top.sv */
// Wake-event interrupt, clock shutdown and remote wakeup with an AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module wkirq_top #(
	parameter int RESUME_CYC = wkirq_pkg::RESUME_CYC
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_suspend,
	input wire logic i_vbus,
	input wire logic i_cd_a,
	input wire logic i_cd_b,
	input wire logic i_gpio4,
	input wire logic i_gpio5,
	output logic o_wake_irq,
	output logic o_core_clk_run,
	output logic o_resume_start
);
	localparam int NS = wkirq_pkg::NSRC;
	localparam int CW = $clog2(RESUME_CYC + 1);

	initial begin
		if (RESUME_CYC < 2) begin
			$error("RESUME_CYC must be at least 2");
		end
	end

	typedef struct packed {
		logic aw_hold;
		logic [7:0] aw_addr;
		logic w_hold;
		logic [7:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [7:0] status;
		logic [7:0] mask;
		logic [7:0] control;
		logic [7:0] cpu_cfg;
		logic [NS-1:0] src;
		logic [NS-1:0] pin_prev;
		logic primed;
		logic woken;
		logic clk_run;
		logic irq;
		logic resume;
		wkirq_pkg::wkirq_rs_t rs;
		logic [CW-1:0] cnt;
	} wkirq_st_t;

	wkirq_st_t r_r;
	wkirq_st_t r_nxt;

	logic [NS-1:0] late_evt;
	logic [NS-1:0] cap_evt;

	// Word decode on byte address, low two bits ignored
	function automatic logic wkirq_hit(input logic [7:0] addr, input logic [7:0] off);
		wkirq_hit = (addr[7:2] == off[7:2]);
	endfunction : wkirq_hit

	function automatic logic wkirq_mapped(input logic [7:0] addr);
		wkirq_mapped = wkirq_hit(addr, wkirq_pkg::OFF_STATUS)
			| wkirq_hit(addr, wkirq_pkg::OFF_MASK)
			| wkirq_hit(addr, wkirq_pkg::OFF_CONTROL)
			| wkirq_hit(addr, wkirq_pkg::OFF_CPU_CFG)
			| wkirq_hit(addr, wkirq_pkg::OFF_WK_SRC);
	endfunction : wkirq_mapped

	////////////////////////////////////////////////////////////////
	// Events caught while the clock is stopped
	wkirq_sync_latch #(
		.W(NS)
	) u_latch (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_capture(cap_evt),
		.i_release(r_r.clk_run),
		.o_evt(late_evt)
	);

	////////////////////////////////////////////////////////////////
	// Whole next-state computation
	always_comb begin
		logic [NS-1:0] pins;
		logic [NS-1:0] det_en;
		logic [NS-1:0] pulse;
		logic [NS-1:0] live;
		logic [NS-1:0] src_clr;
		logic lp_en;
		logic rwu_en;
		logic wake_en;
		logic stopped;
		logic do_wr;
		logic wake_clr;
		logic set_ev;
		logic raise;
		r_nxt = r_r;
		pins = '0;
		det_en = '0;
		pulse = '0;
		live = '0;
		src_clr = '0;
		cap_evt = '0;
		do_wr = 1'b0;
		wake_clr = 1'b0;

		lp_en = r_r.control[wkirq_pkg::BIT_LP_EN];
		rwu_en = r_r.control[wkirq_pkg::BIT_RWU_EN];
		wake_en = r_r.mask[wkirq_pkg::BIT_WAKE_EN];

		// Change detectors: one-cycle pulse per edge of each pin
		pins[wkirq_pkg::SRC_VBUS] = i_vbus;
		pins[wkirq_pkg::SRC_CDA] = i_cd_a;
		pins[wkirq_pkg::SRC_CDB] = i_cd_b;
		pins[wkirq_pkg::SRC_GPIO4] = i_gpio4;
		pins[wkirq_pkg::SRC_GPIO5] = i_gpio5;
		det_en[wkirq_pkg::SRC_VBUS] = 1'b1;
		det_en[wkirq_pkg::SRC_CDA] = r_r.cpu_cfg[wkirq_pkg::BIT_CDA_EN];
		det_en[wkirq_pkg::SRC_CDB] = r_r.cpu_cfg[wkirq_pkg::BIT_CDB_EN];
		det_en[wkirq_pkg::SRC_GPIO4] = r_r.cpu_cfg[wkirq_pkg::BIT_GPIO4_EN];
		det_en[wkirq_pkg::SRC_GPIO5] = r_r.cpu_cfg[wkirq_pkg::BIT_GPIO5_EN];
		// Primed flag stops the reset value of pin_prev faking an edge
		pulse = (pins ^ r_r.pin_prev) & det_en & {NS{r_r.primed}};
		r_nxt.pin_prev = pins;
		r_nxt.primed = 1'b1;

		// Clock stops only in suspend with low power on
		stopped = i_suspend & lp_en & ~r_r.woken;
		if (stopped && rwu_en && wake_en && (|pulse)) begin
			r_nxt.woken = 1'b1;
			live = pulse;
		end else if (stopped) begin
			cap_evt = pulse;
		end else begin
			live = pulse | late_evt;
		end
		// Host resume ends suspend and gives the clock back
		if (!i_suspend) begin
			r_nxt.woken = 1'b0;
		end
		r_nxt.clk_run = ~(i_suspend & lp_en & ~r_nxt.woken);

		////////////////////////////////////////////////////////////
		// Write channel: address and data taken in either order
		if (i_awvalid && r_r.awready) begin
			r_nxt.aw_hold = 1'b1;
			r_nxt.aw_addr = i_awaddr;
		end
		if (i_wvalid && r_r.wready) begin
			r_nxt.w_hold = 1'b1;
			r_nxt.w_data = i_wdata[7:0];
			r_nxt.w_lane0 = i_wstrb[0];
		end
		if (r_r.bvalid && i_bready) begin
			r_nxt.bvalid = 1'b0;
		end
		if (r_r.aw_hold && r_r.w_hold && !r_r.bvalid) begin
			do_wr = r_r.w_lane0;
			r_nxt.aw_hold = 1'b0;
			r_nxt.w_hold = 1'b0;
			r_nxt.bvalid = 1'b1;
			r_nxt.bresp = wkirq_mapped(r_r.aw_addr) ? wkirq_pkg::RESP_OKAY
				: wkirq_pkg::RESP_SLVERR;
		end
		if (do_wr) begin
			if (wkirq_hit(r_r.aw_addr, wkirq_pkg::OFF_STATUS)) begin
				wake_clr = r_r.w_data[wkirq_pkg::BIT_WAKE];
			end
			if (wkirq_hit(r_r.aw_addr, wkirq_pkg::OFF_MASK)) begin
				r_nxt.mask = r_r.w_data;
			end
			if (wkirq_hit(r_r.aw_addr, wkirq_pkg::OFF_CONTROL)) begin
				r_nxt.control = r_r.w_data;
			end
			if (wkirq_hit(r_r.aw_addr, wkirq_pkg::OFF_CPU_CFG)) begin
				r_nxt.cpu_cfg = r_r.w_data;
			end
			if (wkirq_hit(r_r.aw_addr, wkirq_pkg::OFF_WK_SRC)) begin
				src_clr = r_r.w_data[NS-1:0];
			end
		end
		// Each ready only while its own channel holds nothing and no response is pending, so one write at a time
		r_nxt.awready = ~r_nxt.aw_hold & ~r_nxt.bvalid;
		r_nxt.wready = ~r_nxt.w_hold & ~r_nxt.bvalid;

		////////////////////////////////////////////////////////////
		// Shared wake bit: set wins over a clear in the same cycle
		set_ev = (|live) & wake_en;
		raise = set_ev & ~r_r.status[wkirq_pkg::BIT_WAKE];
		r_nxt.status[wkirq_pkg::BIT_WAKE] = set_ev
			| (r_r.status[wkirq_pkg::BIT_WAKE] & ~wake_clr);
		// Source bits only clear by their own write of one
		r_nxt.src = live | (r_r.src & ~src_clr);
		r_nxt.irq = r_nxt.status[wkirq_pkg::BIT_WAKE] & r_nxt.mask[wkirq_pkg::BIT_WAKE_EN];

		////////////////////////////////////////////////////////////
		// Resume scheduling after a wake raised in suspend
		r_nxt.resume = 1'b0;
		unique case (r_r.rs)
			wkirq_pkg::RS_IDLE: begin
				if (raise && i_suspend && rwu_en) begin
					r_nxt.rs = wkirq_pkg::RS_WAIT;
					r_nxt.cnt = '0;
				end
			end
			wkirq_pkg::RS_WAIT: begin
				r_nxt.cnt = r_r.cnt + CW'(1);
				// Clear by firmware or the 10 ms budget, first one wins
				if (wake_clr || (r_r.cnt == CW'(RESUME_CYC - 1))) begin
					r_nxt.rs = wkirq_pkg::RS_SEND;
				end
			end
			wkirq_pkg::RS_SEND: begin
				r_nxt.resume = 1'b1;
				r_nxt.rs = wkirq_pkg::RS_IDLE;
			end
			default: begin
				r_nxt.rs = wkirq_pkg::RS_IDLE;
			end
		endcase

		////////////////////////////////////////////////////////////
		// Read channel with registered data
		if (r_r.rvalid && i_rready) begin
			r_nxt.rvalid = 1'b0;
		end
		if (i_arvalid && r_r.arready) begin
			r_nxt.rvalid = 1'b1;
			r_nxt.rresp = wkirq_mapped(i_araddr) ? wkirq_pkg::RESP_OKAY
				: wkirq_pkg::RESP_SLVERR;
			r_nxt.rdata = 8'h00;
			if (wkirq_hit(i_araddr, wkirq_pkg::OFF_STATUS)) begin
				r_nxt.rdata = r_r.status;
			end
			if (wkirq_hit(i_araddr, wkirq_pkg::OFF_MASK)) begin
				r_nxt.rdata = r_r.mask;
			end
			if (wkirq_hit(i_araddr, wkirq_pkg::OFF_CONTROL)) begin
				r_nxt.rdata = r_r.control;
			end
			if (wkirq_hit(i_araddr, wkirq_pkg::OFF_CPU_CFG)) begin
				r_nxt.rdata = r_r.cpu_cfg;
			end
			if (wkirq_hit(i_araddr, wkirq_pkg::OFF_WK_SRC)) begin
				r_nxt.rdata = {{(8 - NS){1'b0}}, r_r.src};
			end
		end
		r_nxt.arready = ~r_nxt.rvalid;
	end

	////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r_r <= '0;
			r_r.status <= wkirq_pkg::RST_REG;
			r_r.mask <= wkirq_pkg::RST_REG;
			r_r.control <= wkirq_pkg::RST_REG;
			r_r.cpu_cfg <= wkirq_pkg::RST_REG;
			r_r.rs <= wkirq_pkg::RS_IDLE;
			r_r.clk_run <= 1'b1;
			r_r.awready <= 1'b1;
			r_r.wready <= 1'b1;
			r_r.arready <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	// Outputs straight from the state flops
	assign o_awready = r_r.awready;
	assign o_wready = r_r.wready;
	assign o_bresp = r_r.bresp;
	assign o_bvalid = r_r.bvalid;
	assign o_arready = r_r.arready;
	assign o_rdata = {24'h000000, r_r.rdata};
	assign o_rresp = r_r.rresp;
	assign o_rvalid = r_r.rvalid;
	assign o_wake_irq = r_r.irq;
	assign o_core_clk_run = r_r.clk_run;
	assign o_resume_start = r_r.resume;
endmodule : wkirq_top

/* verif/wkirq_assertions.sv */
// Port-level assertions for the wake-event interrupt block
`timescale 1ns/1ps
module wkirq_checker #(
	parameter int RESUME_CYC = 50
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic o_awready,
	input wire logic o_arready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_suspend,
	input wire logic o_wake_irq,
	input wire logic o_core_clk_run,
	input wire logic o_resume_start
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);
	logic irq_r;
	int since_r;
	////////////////////////////////////////////////////////////////
	// Age of the latest wake interrupt, so a resume with no cause stands out
	always_ff @(posedge i_clk) begin
		irq_r <= o_wake_irq;
		if (i_srst)
			since_r <= 1000000;
		else if (o_wake_irq && !irq_r)
			since_r <= 0;
		else if (since_r < 1000000)
			since_r <= since_r + 1;
	end
	////////////////////////////////////////////////////////////////
	// Wake, clock and resume relations
	a_resume_pulse: assert property (o_resume_start |=> !o_resume_start)
		else $error("resume start longer than one cycle");
	a_resume_after_irq: assert property (o_resume_start |-> since_r <= RESUME_CYC + 6)
		else $error("resume start without a recent wake interrupt");
	a_run_awake: assert property (!i_suspend [*3] |-> o_core_clk_run)
		else $error("core clock stopped outside suspend");
	a_quiet_stopped: assert property (!o_core_clk_run |-> !$rose(o_wake_irq))
		else $error("wake interrupt raised while the clock is stopped");
	a_irq_fall_write: assert property ($fell(o_wake_irq) |->
		o_bvalid || $past(o_bvalid) || $past(i_srst))
		else $error("wake interrupt dropped without a register write");
	// Bus handshakes
	a_write_answer: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready)
		else $error("write response not retired");
	a_read_answer: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
		else $error("read response not retired");
	a_aw_refused: assert property (o_bvalid |-> !o_awready)
		else $error("write address open while response pending");
	a_ar_refused: assert property (o_rvalid |-> !o_arready)
		else $error("read address open while data pending");
endmodule : wkirq_checker

bind wkirq_top wkirq_checker #(.RESUME_CYC(RESUME_CYC)) i_wkirq_checker (
	.i_clk(i_clk), .i_srst(i_srst), .o_awready(o_awready), .o_arready(o_arready),
	.o_bvalid(o_bvalid), .i_bready(i_bready), .o_rvalid(o_rvalid), .i_rready(i_rready),
	.i_suspend(i_suspend), .o_wake_irq(o_wake_irq), .o_core_clk_run(o_core_clk_run),
	.o_resume_start(o_resume_start)
);

/* verif/wkirq_host_model.sv */
// Upstream host model: drives suspend and counts resume signalling
`timescale 1ns/1ps
module wkirq_host_model (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_sleep,
	input wire logic i_wake_host,
	input wire logic i_resume_start,
	output logic o_suspend,
	output int o_resumes
);
	// Suspend lasts until the host resumes or the device signals resume
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_suspend <= 1'h0;
			o_resumes <= 0;
		end else begin
			o_suspend <= (o_suspend | i_sleep) & ~i_wake_host & ~i_resume_start;
			o_resumes <= o_resumes + int'(i_resume_start);
		end
	end
endmodule : wkirq_host_model

/* verif/tb_top.sv */
// Register-level tests of the wake-event interrupt block
`timescale 1ns/1ps
module tb_top;
	localparam int RC = 50;
	localparam logic [7:0] ST = wkirq_pkg::OFF_STATUS;
	localparam logic [7:0] MK = wkirq_pkg::OFF_MASK;
	localparam logic [7:0] CT = wkirq_pkg::OFF_CONTROL;
	localparam logic [7:0] CF = wkirq_pkg::OFF_CPU_CFG;
	localparam logic [7:0] WS = wkirq_pkg::OFF_WK_SRC;
	localparam logic [31:0] WK = 32'h1 << wkirq_pkg::BIT_WAKE;
	localparam logic [31:0] LP = 32'h1 << wkirq_pkg::BIT_LP_EN;
	localparam logic [31:0] RW = 32'h1 << wkirq_pkg::BIT_RWU_EN;
	localparam logic [1:0] OK = wkirq_pkg::RESP_OKAY;
	logic i_clk = 1'h0;
	logic i_srst = 1'h1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [4:0] pins = 5'h00;
	logic sleep = 1'h0, wake_host = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, irq, clk_run, resume, suspend;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int resumes;
	int fails = 0;
	int comparisons = 0;
	int en [5] = '{0, wkirq_pkg::BIT_CDA_EN, wkirq_pkg::BIT_CDB_EN,
		wkirq_pkg::BIT_GPIO4_EN, wkirq_pkg::BIT_GPIO5_EN};

	// 40 MHz clock
	initial forever #12.5 i_clk = ~i_clk;

	wkirq_top #(.RESUME_CYC(RC)) i_wkirq_top (
		.i_clk(i_clk), .i_srst(i_srst), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_suspend(suspend),
		.i_vbus(pins[0]), .i_cd_a(pins[1]), .i_cd_b(pins[2]), .i_gpio4(pins[3]),
		.i_gpio5(pins[4]), .o_wake_irq(irq), .o_core_clk_run(clk_run),
		.o_resume_start(resume)
	);
	wkirq_host_model i_wkirq_host_model (
		.i_clk(i_clk), .i_srst(i_srst), .i_sleep(sleep), .i_wake_host(wake_host),
		.i_resume_start(resume), .o_suspend(suspend), .o_resumes(resumes)
	);
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge i_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge i_clk); while (!bvalid);
		bready <= 1'h0;
		chk("bresp", 32'(OK), 32'(bresp));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge i_clk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge i_clk); while (!rvalid);
		rready <= 1'h0;
		chk("rdata", e, rdata);
		chk("rresp", 32'(r), 32'(rresp));
	endtask : rd
	task automatic tog(input int i);
		@(posedge i_clk);
		pins[i] <= ~pins[i];
		repeat (4) @(posedge i_clk);
	endtask : tog
	// Enter suspend (s=1) or have the host resume us (s=0)
	task automatic host(input logic s);
		@(posedge i_clk);
		sleep <= s;
		wake_host <= ~s;
		@(posedge i_clk);
		sleep <= 1'h0;
		wake_host <= 1'h0;
		repeat (5) @(posedge i_clk);
	endtask : host
	task automatic clr();
		wr(ST, WK);
		wr(WS, 32'h1f);
	endtask : clr
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////
	// Hang guard, far beyond the longest expected run
	initial begin
		repeat (20000) @(posedge i_clk);
		fails++;
		print_verdict();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge i_clk);
		i_srst <= 1'h0;
		foreach (en[k]) rd(8'(4 * k), 32'h0, OK);
		rd(8'h20, 32'h0, wkirq_pkg::RESP_SLVERR);
		$display("test reset done");
		tog(0);
		rd(WS, 32'h1, OK);
		rd(ST, 32'h0, OK);
		chk("irq", 32'h0, 32'(irq));
		wr(WS, 32'h1f);
		wr(MK, WK);
		for (int s = 1; s < 5; s++) begin
			wr(CF, 32'h1 << en[s]);
			for (int k = 1; k < 5; k++) tog(k);
			rd(WS, 32'h1 << s, OK);
			clr();
		end
		$display("test enables done");
		wr(CF, 32'h3c);
		for (int k = 0; k < 5; k++) tog(k);
		rd(ST, WK, OK);
		chk("irq", 32'h1, 32'(irq));
		wr(ST, WK);
		rd(ST, 32'h0, OK);
		chk("irq", 32'h0, 32'(irq));
		rd(WS, 32'h1f, OK);
		wr(WS, 32'h8);
		rd(WS, 32'h17, OK);
		wr(WS, 32'h1f);
		rd(WS, 32'h0, OK);
		$display("test clearing done");
		host(1'h1);
		chk("clk_run", 32'h1, 32'(clk_run));
		tog(3);
		chk("irq", 32'h1, 32'(irq));
		repeat (RC + 10) @(posedge i_clk);
		chk("resumes", 32'h0, 32'(resumes));
		clr();
		host(1'h0);
		$display("test running suspend done");
		wr(CT, LP);
		host(1'h1);
		chk("clk_run", 32'h0, 32'(clk_run));
		tog(1);
		repeat (10) @(posedge i_clk);
		chk("irq", 32'h0, 32'(irq));
		host(1'h0);
		repeat (5) @(posedge i_clk);
		chk("irq", 32'h1, 32'(irq));
		rd(WS, 32'h2, OK);
		chk("resumes", 32'h0, 32'(resumes));
		clr();
		$display("test captured event done");
		wr(CT, LP | RW);
		host(1'h1);
		chk("clk_run", 32'h0, 32'(clk_run));
		tog(2);
		chk("clk_run", 32'h1, 32'(clk_run));
		chk("irq", 32'h1, 32'(irq));
		repeat (RC - 8) @(posedge i_clk);
		chk("resumes", 32'h0, 32'(resumes));
		repeat (12) @(posedge i_clk);
		chk("resumes", 32'h1, 32'(resumes));
		clr();
		$display("test resume timeout done");
		host(1'h1);
		tog(4);
		wr(ST, WK);
		repeat (6) @(posedge i_clk);
		chk("resumes", 32'h2, 32'(resumes));
		rd(WS, 32'h10, OK);
		$display("test resume on clear done");
		print_verdict();
	end
endmodule : tb_top
